// ### include/riw_pkg.sv
/*
  Shared constants and carrier types for the remote I/O watchdog port.
  Assumes a single 10 MHz system clock and no register bus.
*/
package riw_pkg;

  // ********************************************************************
  // Clock and timing
  // ********************************************************************
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned SETUP_BAUD = 115_200;
  localparam int unsigned OPERATE_BAUD_DEFAULT = 2_500_000;
  localparam int unsigned WDOG_MS_DEFAULT = 50;
  localparam int unsigned MS_HZ = 1000;
  localparam int unsigned CYCLES_PER_MS = CLK_HZ / MS_HZ;
  // Bit time in cycles, rounded down and never below one.
  localparam int unsigned SETUP_DIV = (CLK_HZ / SETUP_BAUD) < 1 ? 1 : CLK_HZ / SETUP_BAUD;
  localparam int unsigned OPERATE_DIV_DEFAULT = (CLK_HZ / OPERATE_BAUD_DEFAULT) < 1 ? 1 :
    CLK_HZ / OPERATE_BAUD_DEFAULT;

  // ********************************************************************
  // Widths and reset values
  // ********************************************************************
  localparam int unsigned IO_W = 48;
  localparam int unsigned HDR_W = 24;
  localparam int unsigned DIV_W = 16;
  localparam int unsigned WDOG_W = 16;
  localparam logic [IO_W-1:0] PIN_OFF = 48'hFFFFFFFFFFFF;
  localparam logic [IO_W-1:0] OUT_RESET = 48'h000000000000;
  localparam logic FAULT_RESET = 1'b1;

  // Process data exchanged with the host on each transfer.
  typedef struct packed {
    logic [IO_W-1:0] bits;
  } riw_pd_t;

  // Two header pin groups.
  typedef struct packed {
    logic [HDR_W-1:0] high_io_header;
    logic [HDR_W-1:0] low_io_header;
  } riw_hdr_t;

  typedef enum logic {
    RIW_ASCENDING,
    RIW_DESCENDING
  } riw_order_t;

endpackage

// ### verilog/riw_port.sv
/*
  Remote 48-bit digital I/O port core: header mapping, pin inversion,
  watchdog and fault flag, and link bit-rate enable selection.
  Assumes the serial framing logic outside hands over each valid exchange
  as one pulse with its output word, and uses the bit-rate enable here.
*/
//
// Contract
// - Setup jumper forces fixed 115.2 KBaud rate.
// - Operate jumper uses configurable rate, default 2.5M.
// - Order jumper reverses bits within each header.
// - Bits 0-23 low header, 24-47 high.
// - Pins inverted: low reads one, one drives low.
// - Power-up and watchdog expiry release pins high.
// - Watchdog expiry turns outputs off, sets fault.
// - Fault set blocks output updates until cleared.
// - Fault flag set out of power-up.
// - Each exchange carries 48 out, 48 in.
// - Watchdog period zero disables the watchdog.
`timescale 1ns/1ns
module riw_port #(
  parameter int unsigned OPERATE_DIV = riw_pkg::OPERATE_DIV_DEFAULT,
  parameter int unsigned CYCLES_PER_MS = riw_pkg::CYCLES_PER_MS
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic mode_select_jumper,
  input wire logic pinout_order_jumper,
  input wire logic [riw_pkg::WDOG_W-1:0] watchdog_ms,
  input wire logic xfer_valid,
  input wire riw_pkg::riw_pd_t xfer_out,
  output riw_pkg::riw_pd_t xfer_in,
  input wire logic fault_clear,
  output logic fault,
  output logic baud_tick,
  input wire riw_pkg::riw_hdr_t pin_in,
  output riw_pkg::riw_hdr_t pin_out,
  output riw_pkg::riw_hdr_t pin_oe_n
);

  // ********************************************************************
  // Header mapping
  // ********************************************************************

  // Reverse the bit numbering within one header.
  function automatic logic [riw_pkg::HDR_W-1:0] rev24(input logic [riw_pkg::HDR_W-1:0] v);
    logic [riw_pkg::HDR_W-1:0] r;
    r = '0;
    for (int i = 0; i < riw_pkg::HDR_W; i++) begin
      r[i] = v[riw_pkg::HDR_W-1-i];
    end
    return r;
  endfunction

  // Map a 48-bit word onto or off the headers; the mapping is its own inverse.
  function automatic riw_pkg::riw_hdr_t map_hdr(input logic [riw_pkg::IO_W-1:0] v, input logic desc);
    riw_pkg::riw_hdr_t h;
    h.low_io_header = desc ? rev24(v[riw_pkg::HDR_W-1:0]) : v[riw_pkg::HDR_W-1:0];
    h.high_io_header = desc ? rev24(v[riw_pkg::IO_W-1:riw_pkg::HDR_W]) :
      v[riw_pkg::IO_W-1:riw_pkg::HDR_W];
    return h;
  endfunction

  logic [riw_pkg::IO_W-1:0] out_bits;
  logic [riw_pkg::IO_W-1:0] next_out_bits;
  logic [riw_pkg::IO_W-1:0] next_in_bits;
  logic desc_order;
  riw_pkg::riw_hdr_t mapped_out;
  riw_pkg::riw_hdr_t pin_level;

  assign desc_order = (pinout_order_jumper == 1'b1);
  // Inputs are sampled as reported host bits: a low pin reads as one.
  assign pin_level = ~pin_in;
  assign next_in_bits = map_hdr(pin_level, desc_order);

  // Output bit one means pin low. Open drain: drive only while on, else release to the pullup.
  // Host bits set to zero therefore leave the pin free to be read as an input.
  assign mapped_out = map_hdr(out_bits, desc_order);

  // ********************************************************************
  // Watchdog and fault
  // ********************************************************************
  logic [riw_pkg::WDOG_W-1:0] wd_ms_left;
  logic [31:0] ms_cnt;
  logic wd_enabled;
  logic ms_tick;
  logic wd_bite;
  logic exch_ok;

  // With a period of N milliseconds the bite lands N whole milliseconds after the
  // last exchange; an exchange in the bite cycle itself wins, so a host that is just
  // in time is never punished for it.
  assign wd_enabled = (watchdog_ms != '0);
  assign ms_tick = (ms_cnt == CYCLES_PER_MS - 1);
  assign wd_bite = wd_enabled && ms_tick && (wd_ms_left == 16'h0001) && !xfer_valid;
  // Output words are honoured only while no fault stands.
  assign exch_ok = xfer_valid && !fault;
  // A bite forces all outputs off; a faulted exchange leaves them alone.
  assign next_out_bits = wd_bite ? riw_pkg::OUT_RESET :
    exch_ok ? xfer_out.bits : out_bits;

  // Millisecond prescaler restarted by each exchange so the period is measured from it.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ms_cnt <= '0;
    end else if (xfer_valid || ms_tick) begin
      ms_cnt <= '0;
    end else begin
      ms_cnt <= ms_cnt + 32'h00000001;
    end
  end

  // Countdown in milliseconds, reloaded on every exchange.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wd_ms_left <= 16'h0000;
    end else if (xfer_valid || !wd_enabled) begin
      wd_ms_left <= watchdog_ms;
    end else if (ms_tick && wd_ms_left != 16'h0000) begin
      wd_ms_left <= wd_ms_left - 16'h0001;
    end
  end

  // Fault flag: set at reset and by a bite; the bite wins over a clear in the same cycle.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      fault <= riw_pkg::FAULT_RESET;
    end else if (wd_bite) begin
      fault <= 1'b1;
    end else if (fault_clear) begin
      fault <= 1'b0;
    end
  end

  // Output image and captured input image.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      out_bits <= riw_pkg::OUT_RESET;
      xfer_in <= '0;
    end else begin
      out_bits <= next_out_bits;
      xfer_in.bits <= next_in_bits;
    end
  end

  // Registered pin drivers; pins released high after reset.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pin_out <= riw_pkg::PIN_OFF;
      pin_oe_n <= riw_pkg::PIN_OFF;
    end else begin
      pin_out <= '0;
      pin_oe_n <= ~next_map(next_out_bits, desc_order);
    end
  end

  // Helper to keep pin drive aligned with the output image.
  function automatic riw_pkg::riw_hdr_t next_map(input logic [riw_pkg::IO_W-1:0] v, input logic d);
    return map_hdr(v, d);
  endfunction

  // ********************************************************************
  // Link bit-rate enable
  // ********************************************************************
  logic [riw_pkg::DIV_W-1:0] baud_cnt;
  logic [riw_pkg::DIV_W-1:0] baud_div;
  localparam logic [riw_pkg::DIV_W-1:0] SETUP_DIV_W = riw_pkg::DIV_W'(riw_pkg::SETUP_DIV);
  localparam logic [riw_pkg::DIV_W-1:0] OPER_DIV_W = riw_pkg::DIV_W'(OPERATE_DIV);

  // Jumper low selects setup, which ignores any configured rate.
  assign baud_div = (mode_select_jumper == 1'b0) ? SETUP_DIV_W : OPER_DIV_W;

  // Divider emits one enable pulse per bit time; a rate change restarts cleanly at wrap.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      baud_cnt <= '0;
      baud_tick <= 1'b0;
    end else if (baud_cnt >= baud_div - 16'h0001) begin
      baud_cnt <= '0;
      baud_tick <= 1'b1;
    end else begin
      baud_cnt <= baud_cnt + 16'h0001;
      baud_tick <= 1'b0;
    end
  end

  // ********************************************************************
  // Assertions
  // ********************************************************************
  // Every property samples on the system clock; all but AST_FAULT_AT_START and AST_RESET_RELEASE stand down while reset is high.
  AST_FAULT_AT_START: assert property (@(posedge clk_sys) $fell(reset) |-> fault)
    else $error("fault not set after reset");
  AST_BITE_SETS_FAULT: assert property (@(posedge clk_sys) disable iff (reset)
    wd_bite |=> fault && out_bits == '0)
    else $error("bite did not fault and clear outputs");
  AST_FAULT_BLOCKS: assert property (@(posedge clk_sys) disable iff (reset)
    fault && !fault_clear ##0 $stable(fault) |=> $stable(out_bits) || out_bits == '0)
    else $error("output changed while faulted");
  AST_ZERO_NO_BITE: assert property (@(posedge clk_sys) disable iff (reset)
    watchdog_ms == '0 |-> !wd_bite)
    else $error("bite with watchdog disabled");
  AST_RELOAD: assert property (@(posedge clk_sys) disable iff (reset)
    xfer_valid |=> wd_ms_left == $past(watchdog_ms))
    else $error("watchdog not reloaded");
  AST_ACCEPT: assert property (@(posedge clk_sys) disable iff (reset)
    xfer_valid && !fault && !wd_bite |=> out_bits == $past(xfer_out.bits))
    else $error("output word not taken");
  AST_PIN_INVERT: assert property (@(posedge clk_sys) disable iff (reset)
    1'b1 |=> pin_oe_n == ~map_hdr(out_bits, $past(desc_order)))
    else $error("pin drive not inverted");
  AST_SETUP_RATE: assert property (@(posedge clk_sys) disable iff (reset)
    !mode_select_jumper |-> baud_div == SETUP_DIV_W)
    else $error("setup rate not fixed");
  AST_OPER_RATE: assert property (@(posedge clk_sys) disable iff (reset)
    mode_select_jumper |-> baud_div == OPER_DIV_W)
    else $error("operate rate wrong");
  AST_ORDER: assert property (@(posedge clk_sys) disable iff (reset)
    desc_order |-> next_in_bits[0] == pin_level.low_io_header[riw_pkg::HDR_W-1])
    else $error("descending order wrong");

  // Once out of reset the drive level is always low; only the enable turns a pin on.
  AST_DRIVE_LEVEL: assert property (@(posedge clk_sys) disable iff (reset)
    !$past(reset) |-> pin_out == '0)
    else $error("pin drive level not low");

  // Leaving reset, every pin is released and the output image is empty.
  AST_RESET_RELEASE: assert property (@(posedge clk_sys)
    $fell(reset) |-> pin_oe_n == riw_pkg::PIN_OFF && out_bits == riw_pkg::OUT_RESET)
    else $error("pins not released after reset");

  // A bite releases every pin in the very next cycle.
  AST_BITE_RELEASE: assert property (@(posedge clk_sys) disable iff (reset)
    wd_bite |=> pin_oe_n == riw_pkg::PIN_OFF)
    else $error("pins not released after bite");

  // Outside reset, the fault flag can only rise through a bite.
  AST_FAULT_RISE: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(fault) |-> $past(wd_bite))
    else $error("fault rose without a bite");

  // A clear that meets no bite takes the flag down at once.
  AST_CLEAR: assert property (@(posedge clk_sys) disable iff (reset)
    fault_clear && !wd_bite |=> !fault)
    else $error("fault clear ignored");

  // Without an exchange or a bite the output image stands.
  AST_HOLD_OUT: assert property (@(posedge clk_sys) disable iff (reset)
    !xfer_valid && !wd_bite |=> $stable(out_bits))
    else $error("output image changed on its own");

  // A word that arrives while faulted is dropped.
  AST_REFUSED: assert property (@(posedge clk_sys) disable iff (reset)
    xfer_valid && fault |=> $stable(out_bits))
    else $error("word taken while faulted");

  // The input image follows the pins one cycle late, inverted and mapped.
  AST_IN_IMAGE: assert property (@(posedge clk_sys) disable iff (reset)
    !$past(reset) |-> xfer_in.bits == map_hdr(~$past(pin_in), $past(desc_order)))
    else $error("input image wrong");

  // With a steady order jumper the enables mirror the current output image.
  AST_PIN_IMAGE: assert property (@(posedge clk_sys) disable iff (reset)
    !$changed(desc_order) |-> pin_oe_n == ~mapped_out)
    else $error("pin enables differ from output image");

  // Ascending order keeps bit zero of each header in place.
  AST_ASC_ORDER: assert property (@(posedge clk_sys) disable iff (reset)
    !desc_order |-> next_in_bits[0] == pin_level.low_io_header[0] &&
      next_in_bits[riw_pkg::HDR_W] == pin_level.high_io_header[0])
    else $error("ascending order wrong");

  // Descending order puts bit zero of the high header at the top of the word.
  AST_DESC_HIGH: assert property (@(posedge clk_sys) disable iff (reset)
    desc_order |-> next_in_bits[riw_pkg::IO_W-1] == pin_level.high_io_header[0])
    else $error("descending high header wrong");

  // The bit-rate enable is a single-cycle pulse whenever the divisor exceeds one.
  AST_TICK_PULSE: assert property (@(posedge clk_sys) disable iff (reset)
    baud_tick && baud_div > 16'h0001 |=> !baud_tick)
    else $error("bit-rate enable longer than one cycle");

  // The millisecond prescaler never passes its terminal count.
  AST_MS_BOUND: assert property (@(posedge clk_sys) disable iff (reset)
    ms_cnt < CYCLES_PER_MS)
    else $error("millisecond prescaler overran");

  // Each millisecond without an exchange takes one off the countdown.
  AST_COUNTDOWN: assert property (@(posedge clk_sys) disable iff (reset)
    ms_tick && !xfer_valid && wd_enabled && wd_ms_left != 16'h0000 |=>
      wd_ms_left == $past(wd_ms_left) - 16'h0001)
    else $error("watchdog countdown skipped");

  // ********************************************************************
  // Cover points
  // ********************************************************************
  // Clear, bite, plain and descending exchanges, and a setup-rate enable.
  COV_CLEAR: cover property (@(posedge clk_sys) disable iff (reset) fault ##1 !fault);
  COV_BITE: cover property (@(posedge clk_sys) disable iff (reset) wd_bite);
  COV_EXCH: cover property (@(posedge clk_sys) disable iff (reset) exch_ok);
  COV_DESC_EXCH: cover property (@(posedge clk_sys) disable iff (reset) exch_ok && desc_order);
  COV_SETUP_TICK: cover property (@(posedge clk_sys) disable iff (reset) baud_tick && !mode_select_jumper);

endmodule // riw_port

// ### tb/riw_host_model.sv
/*
  Host-side model of the serial controller: sends exchanges and fault clears.
  Assumes the bench calls its tasks and shares clk_sys with the port.
*/
`timescale 1ns/1ns
module riw_host_model (
  input wire logic clk_sys,
  output logic xfer_valid,
  output riw_pkg::riw_pd_t xfer_out,
  output logic fault_clear
);
  // Idle at time zero, so the port sees no request before reset ends.
  initial begin
    xfer_valid = 1'b0;
    xfer_out = riw_pkg::riw_pd_t'(48'h0);
    fault_clear = 1'b0;
  end

  // One whole word per request; the released bus shows its inverse.
  task automatic exchange(input logic [47:0] w);
    @(posedge clk_sys);
    xfer_valid <= 1'b1;
    xfer_out <= riw_pkg::riw_pd_t'(w);
    @(posedge clk_sys);
    xfer_valid <= 1'b0;
    xfer_out <= riw_pkg::riw_pd_t'(~w);
  endtask

  // The host must clear the fault before outputs take effect.
  task automatic clear_fault();
    @(posedge clk_sys);
    fault_clear <= 1'b1;
    @(posedge clk_sys);
    fault_clear <= 1'b0;
  endtask
endmodule // riw_host_model

// ### tb/testbench.sv
/*
  Self-checking bench for the remote I/O port with watchdog.
  Assumes the host model drives the exchange side and pins have pullups.
*/
`timescale 1ns/1ns
`define CHK(got, exp, msg) begin samples_checked++; if ((got) !== (exp)) begin errors++; \
  $display("mismatch %0t %s", $time, msg); end end
module testbench;
  logic clk_sys, reset, mode_select_jumper, pinout_order_jumper, fault_clear, xfer_valid, fault, baud_tick;
  logic [riw_pkg::WDOG_W-1:0] watchdog_ms;
  logic [47:0] ext_low, w;
  riw_pkg::riw_pd_t xfer_out, xfer_in;
  riw_pkg::riw_hdr_t pin_in, pin_out, pin_oe_n;
  int errors, samples_checked, n;

  // ****************************************************************
  // Pins, port and host
  // ****************************************************************
  // A pin is low when the port pulls it or an outside switch closes.
  assign pin_in = riw_pkg::riw_hdr_t'(pin_oe_n & ~ext_low);
  riw_port #(.CYCLES_PER_MS(10)) dut_u (.clk_sys(clk_sys), .reset(reset),
    .mode_select_jumper(mode_select_jumper), .pinout_order_jumper(pinout_order_jumper),
    .watchdog_ms(watchdog_ms), .xfer_valid(xfer_valid), .xfer_out(xfer_out), .xfer_in(xfer_in),
    .fault_clear(fault_clear), .fault(fault), .baud_tick(baud_tick), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n));
  riw_host_model host_u (.clk_sys(clk_sys), .xfer_valid(xfer_valid), .xfer_out(xfer_out),
    .fault_clear(fault_clear));

  // Free-running 10 MHz clock.
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Header position of each bit; reversal is its own inverse, so it maps both ways.
  function automatic logic [47:0] map(input logic [47:0] v, input logic d);
    logic [47:0] r;
    for (int i = 0; i < 24; i++) begin
      r[i] = d ? v[23-i] : v[i];
      r[24+i] = d ? v[47-i] : v[24+i];
    end
    return r;
  endfunction

  task automatic finish_test();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Cycles from one bit-rate tick to the next, under a bound.
  task automatic tick_gap(output int g);
    int k;
    k = 0;
    g = 0;
    do begin @(negedge clk_sys); k++; end while (baud_tick !== 1'b1 && k < 200);
    do begin @(negedge clk_sys); g++; end while (baud_tick !== 1'b1 && g < 200);
    if (k >= 200 || g >= 200) begin errors++; finish_test(); end
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    reset = 1'b1;
    mode_select_jumper = 1'b1;
    pinout_order_jumper = 1'b0;
    watchdog_ms = '0;
    ext_low = 48'h0;
    errors = 0;
    samples_checked = 0;
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    @(negedge clk_sys);
    `CHK(fault, 1'b1, "fault clear after reset")
    `CHK(pin_oe_n, riw_pkg::PIN_OFF, "pins not released")
    host_u.exchange(48'hFFFFFFFFFFFF);
    @(negedge clk_sys);
    `CHK(pin_oe_n, riw_pkg::PIN_OFF, "word taken under fault")
    `CHK(pin_out, 48'h0, "pin drive level")
    host_u.clear_fault();
    @(negedge clk_sys);
    `CHK(fault, 1'b0, "fault not cleared")
    repeat (100) @(negedge clk_sys);
    `CHK(fault, 1'b0, "disabled watchdog bit")
    // Both orders, outputs first, then every pin released and read.
    for (int d = 0; d < 2; d++) begin
      @(posedge clk_sys);
      pinout_order_jumper <= d[0];
      w = 48'hC0FFEE123456;
      host_u.exchange(w);
      @(negedge clk_sys);
      `CHK(pin_oe_n, ~map(w, d[0]), "output mapping")
      host_u.exchange(48'h0);
      ext_low <= 48'h80000100F00A;
      repeat (2) @(negedge clk_sys);
      `CHK(xfer_in, map(ext_low, d[0]), "input mapping")
    end
    // Exchanges 14 cycles apart keep a 20-cycle watchdog fed.
    @(posedge clk_sys);
    watchdog_ms <= 16'h0002;
    repeat (4) begin
      host_u.exchange(48'h000000000005);
      repeat (12) @(posedge clk_sys);
    end
    @(negedge clk_sys);
    `CHK(fault, 1'b0, "bite while fed")
    n = 0;
    while (fault !== 1'b1 && n < 30) begin @(negedge clk_sys); n++; end
    `CHK(fault, 1'b1, "no bite")
    if (n >= 30) finish_test();
    `CHK(pin_oe_n, riw_pkg::PIN_OFF, "pins on after bite")
    host_u.exchange(48'h000000000001);
    @(negedge clk_sys);
    `CHK(pin_oe_n, riw_pkg::PIN_OFF, "word taken after bite")
    // Bit time in each mode, measured on the third gap.
    @(posedge clk_sys);
    mode_select_jumper <= 1'b0;
    tick_gap(n);
    tick_gap(n);
    `CHK(n, riw_pkg::SETUP_DIV, "setup bit time")
    @(posedge clk_sys);
    mode_select_jumper <= 1'b1;
    tick_gap(n);
    tick_gap(n);
    `CHK(n, riw_pkg::OPERATE_DIV_DEFAULT, "operate bit time")
    finish_test();
  end
endmodule // testbench
